/* File: codec_pwr_pkg.sv */
package codec_pwr_pkg;
   localparam int CPC_OFFSET = 5;
   localparam int BIT_CORE_PD = 15;
   localparam int BIT_SIDETONE_PD = 13;
   localparam int BIT_DRIVER_SEL = 12;
   localparam int BIT_SIDETONE_DONE = 11;
   localparam int BIT_PLAYBACK_PD = 10;
   localparam int BIT_RECORD_PD = 9;
   localparam int BIT_VIRTUAL_GROUND_PD = 8;
   localparam int BIT_RECORD_DONE = 7;
   localparam int BIT_PLAYBACK_DONE = 6;
   localparam int BIT_WS_FUNC = 5;
   localparam int BIT_BIAS_SEL = 4;
   localparam int BIT_EFFECTS_EN = 1;
   localparam int BIT_DEEMPH_EN = 0;
   localparam logic [15:0] CPC_RESET = 16'hAFC0;
   localparam logic [15:0] CPC_WRITE_MASK = 16'hB733;
   localparam logic [15:0] CPC_RESERVED_MASK = 16'h400C;
endpackage

/* File: pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
   parameter bit INIT = 1'b0
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Asynchronous level and its filtered copy
   input wire logic async_in,
   output logic level_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } sync_state_t;

   sync_state_t s;
   sync_state_t next_s;

   // A change is taken only when the second and third stages agree, so one late stage cannot glitch it.
   always_comb
   begin
      next_s = s;
      next_s.s1 = async_in;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      if (s.s2 == s.s3)
      begin
         next_s.level = s.s3;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         s <= {INIT, INIT, INIT, INIT};
      end
      else
      begin
         s <= next_s;
      end
   end

   assign level_out = s.level;
endmodule

/* File: codec_power_control_reg.sv */
`timescale 1ns/1ps
module codec_power_control_reg
   import codec_pwr_pkg::*;
#(
   parameter int AW = 7
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Register access from the serial control port
   input wire logic reg_wr_en_in,
   input wire logic reg_rd_en_in,
   input wire logic [AW-1:0] reg_addr_in,
   input wire logic [15:0] reg_wr_data_in,
   output logic [15:0] reg_rd_data_out,
   output logic reg_rd_valid_out,
   // Power-down completion from the analog blocks, high when fully off
   input wire logic sidetone_off_in,
   input wire logic record_conv_off_in,
   input wire logic playback_conv_off_in,
   // Pins
   input wire logic record_word_select_pin_in,
   input wire logic playback_lr_clock_in,
   // Power-down controls
   output logic codec_core_pd_out,
   output logic sidetone_analog_pd_out,
   output logic playback_conv_pd_out,
   output logic record_conv_pd_out,
   output logic virtual_ground_amp_pd_out,
   output logic hw_pd_out,
   // Mode controls
   output logic out_driver_power_sel_out,
   output logic record_ws_pin_func_out,
   output logic bias_level_sel_out,
   output logic effects_filter_en_out,
   output logic deemphasis_en_out,
   output logic record_ws_out,
   // Completion flags
   output logic sidetone_pd_done_out,
   output logic record_conv_pd_done_out,
   output logic playback_conv_pd_done_out
);
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] rd_data;
      logic rd_valid;
      logic core_pd;
      logic sidetone_pd;
      logic playback_pd;
      logic record_pd;
      logic virtual_ground_pd;
      logic hw_pd;
      logic record_ws;
      logic sidetone_done;
      logic record_done;
      logic playback_done;
   } cpc_state_t;

   cpc_state_t s;
   cpc_state_t next_s;
   logic addr_hit;
   logic sidetone_off;
   logic record_off;
   logic playback_off;
   logic ws_pin;
   logic lr_clock;

   // Completion inputs idle high so the flags read 1 straight out of reset.
   pin_sync #(.INIT(1'b1)) u_sync_sidetone (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .async_in(sidetone_off_in),
      .level_out(sidetone_off)
   );

   pin_sync #(.INIT(1'b1)) u_sync_record (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .async_in(record_conv_off_in),
      .level_out(record_off)
   );

   pin_sync #(.INIT(1'b1)) u_sync_playback (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .async_in(playback_conv_off_in),
      .level_out(playback_off)
   );

   pin_sync #(.INIT(1'b0)) u_sync_ws_pin (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .async_in(record_word_select_pin_in),
      .level_out(ws_pin)
   );

   pin_sync #(.INIT(1'b0)) u_sync_lr_clock (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .async_in(playback_lr_clock_in),
      .level_out(lr_clock)
   );

   assign addr_hit = (reg_addr_in == AW'(CPC_OFFSET));

   always_comb
   begin
      next_s = s;
      next_s.rd_valid = 1'b0;
      // Only writable bits take the written value; flags and reserved bits are never stored.
      if (reg_wr_en_in && addr_hit)
      begin
         next_s.ctrl = reg_wr_data_in & CPC_WRITE_MASK;
      end
      // The pin acts as an active-high hardware power-down only while it is not a word select.
      next_s.hw_pd = !next_s.ctrl[BIT_WS_FUNC] && ws_pin;
      // The codec-wide power-down also forces every sub-block down, so no path runs without the core.
      next_s.core_pd = next_s.ctrl[BIT_CORE_PD] || next_s.hw_pd;
      next_s.sidetone_pd = next_s.ctrl[BIT_SIDETONE_PD] || next_s.core_pd;
      next_s.playback_pd = next_s.ctrl[BIT_PLAYBACK_PD] || next_s.core_pd;
      next_s.record_pd = next_s.ctrl[BIT_RECORD_PD] || next_s.core_pd;
      next_s.virtual_ground_pd = next_s.ctrl[BIT_VIRTUAL_GROUND_PD] || next_s.core_pd;
      // A flag shows done only while power-down is requested and the block reports itself off.
      next_s.sidetone_done = next_s.sidetone_pd && sidetone_off;
      next_s.record_done = next_s.record_pd && record_off;
      next_s.playback_done = next_s.playback_pd && playback_off;
      // Without its own word select the record side runs on the playback frame clock.
      if (next_s.ctrl[BIT_WS_FUNC])
      begin
         next_s.record_ws = ws_pin;
      end
      else
      begin
         next_s.record_ws = lr_clock;
      end
      // A read returns the value held before any write in the same cycle; unmapped reads give zero.
      if (reg_rd_en_in)
      begin
         next_s.rd_valid = 1'b1;
         next_s.rd_data = 16'h0000;
         if (addr_hit)
         begin
            next_s.rd_data = s.ctrl & ~CPC_RESERVED_MASK;
            next_s.rd_data[BIT_SIDETONE_DONE] = s.sidetone_done;
            next_s.rd_data[BIT_RECORD_DONE] = s.record_done;
            next_s.rd_data[BIT_PLAYBACK_DONE] = s.playback_done;
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         s <= '0;
         s.ctrl <= CPC_RESET & CPC_WRITE_MASK;
         s.core_pd <= 1'b1;
         s.sidetone_pd <= 1'b1;
         s.playback_pd <= 1'b1;
         s.record_pd <= 1'b1;
         s.virtual_ground_pd <= 1'b1;
         s.sidetone_done <= 1'b1;
         s.record_done <= 1'b1;
         s.playback_done <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign reg_rd_data_out = s.rd_data;
   assign reg_rd_valid_out = s.rd_valid;
   assign codec_core_pd_out = s.core_pd;
   assign sidetone_analog_pd_out = s.sidetone_pd;
   assign playback_conv_pd_out = s.playback_pd;
   assign record_conv_pd_out = s.record_pd;
   assign virtual_ground_amp_pd_out = s.virtual_ground_pd;
   assign hw_pd_out = s.hw_pd;
   // The mode bits are plain register bits, so they leave straight from the stored copy.
   assign out_driver_power_sel_out = s.ctrl[BIT_DRIVER_SEL];
   assign record_ws_pin_func_out = s.ctrl[BIT_WS_FUNC];
   assign bias_level_sel_out = s.ctrl[BIT_BIAS_SEL];
   assign effects_filter_en_out = s.ctrl[BIT_EFFECTS_EN];
   assign deemphasis_en_out = s.ctrl[BIT_DEEMPH_EN];
   assign record_ws_out = s.record_ws;
   assign sidetone_pd_done_out = s.sidetone_done;
   assign record_conv_pd_done_out = s.record_done;
   assign playback_conv_pd_done_out = s.playback_done;

   default clocking cb @(posedge clk_in);
   endclocking

   default disable iff (srst_in);

   sequence s_write_hit;
      reg_wr_en_in && addr_hit;
   endsequence

   sequence s_read_hit;
      reg_rd_en_in && addr_hit && !reg_wr_en_in;
   endsequence

   a_core_pd_write: assert property (
      s_write_hit ##1 !s.hw_pd |-> codec_core_pd_out == $past(reg_wr_data_in[BIT_CORE_PD]))
      else $error("Codec power-down does not follow the written bit.");

   a_sidetone_pd_write: assert property (
      s_write_hit and reg_wr_data_in[BIT_SIDETONE_PD] |=> sidetone_analog_pd_out)
      else $error("Sidetone is not powered down after writing 1.");

   a_driver_sel_write: assert property (
      s_write_hit |=> out_driver_power_sel_out == $past(reg_wr_data_in[BIT_DRIVER_SEL]))
      else $error("Driver power select does not follow the written bit.");

   a_conv_pd_write: assert property (
      s_write_hit ##1 !codec_core_pd_out |-> playback_conv_pd_out == $past(reg_wr_data_in[BIT_PLAYBACK_PD])
         && record_conv_pd_out == $past(reg_wr_data_in[BIT_RECORD_PD]))
      else $error("Converter power-down does not follow the written bits.");

   a_virtual_ground_core_force: assert property (
      codec_core_pd_out |-> virtual_ground_amp_pd_out && record_conv_pd_out && playback_conv_pd_out)
      else $error("A sub-block runs while the codec is powered down.");

   a_flag_needs_pd: assert property (
      (sidetone_pd_done_out |-> sidetone_analog_pd_out) and (record_conv_pd_done_out |-> record_conv_pd_out)
         and (playback_conv_pd_done_out |-> playback_conv_pd_out))
      else $error("A completion flag is set while its block is powered up.");

   a_flag_readback: assert property (
      s_read_hit ##1 reg_rd_valid_out |-> reg_rd_data_out[BIT_SIDETONE_DONE] == $past(s.sidetone_done)
         && reg_rd_data_out[BIT_RECORD_DONE] == $past(s.record_done)
         && reg_rd_data_out[BIT_PLAYBACK_DONE] == $past(s.playback_done))
      else $error("Read data does not show the live completion flags.");

   a_reserved_zero: assert property (
      reg_rd_valid_out |-> (reg_rd_data_out & CPC_RESERVED_MASK) == 16'h0000)
      else $error("Reserved bits read as nonzero.");

   a_ws_pin_pd: assert property (
      !record_ws_pin_func_out && hw_pd_out |-> codec_core_pd_out)
      else $error("Hardware power-down pin does not power the codec down.");

   a_ws_shared_clock: assert property (
      s.ctrl[BIT_WS_FUNC] == 1'b0 ##1 !record_ws_pin_func_out |-> record_ws_out == $past(lr_clock))
      else $error("Record word select does not follow the playback frame clock.");

   a_bias_write: assert property (
      s_write_hit |=> bias_level_sel_out == $past(reg_wr_data_in[BIT_BIAS_SEL]))
      else $error("Bias select does not follow the written bit.");

   a_filter_write: assert property (
      s_write_hit |=> effects_filter_en_out == $past(reg_wr_data_in[BIT_EFFECTS_EN])
         && deemphasis_en_out == $past(reg_wr_data_in[BIT_DEEMPH_EN]))
      else $error("Filter enables do not follow the written bits.");

   a_read_one_cycle: assert property (
      reg_rd_en_in |=> reg_rd_valid_out ##1 (reg_rd_valid_out == $past(reg_rd_en_in)))
      else $error("Read answer is not a one-cycle pulse per request.");
endmodule

/* File: analog_model.sv */
`timescale 1ns/1ps
// Stands in for the analog blocks: each reports itself fully off only after its
// power-down request has been held for DLY cycles, and on again DLY cycles after release.
module analog_model #(
   parameter int DLY = 3
) (
   // Clock
   input wire logic clk_in,
   // Power-down requests and completion reports
   input wire logic [2:0] pd_in,
   output logic [2:0] off_out = 3'h7
);
   logic [DLY-1:0] hist [3] = '{default: '1};
   always_ff @(posedge clk_in)
   begin
      for (int i = 0; i < 3; i++)
      begin
         hist[i] <= {hist[i][DLY-2:0], pd_in[i]};
         if (&hist[i])
            off_out[i] <= 1'b1;
         else if (~|hist[i])
            off_out[i] <= 1'b0;
      end
   end
endmodule

/* File: codec_power_control_reg_tb.sv */
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) \
      begin \
         fails++; \
         $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end
module codec_power_control_reg_tb;
   import codec_pwr_pkg::*;
   localparam int SETTLE = 12;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [6:0] addr = 7'h00;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata;
   logic rd_valid;
   logic pin = 1'b0;
   logic lrclk = 1'b0;
   logic [2:0] off;
   logic core, side, play, rec, vg, hw, drv, wsf, bias, eff, deem, ws, side_d, rec_d, play_d;
   int fails = 0;
   int n_checks = 0;
   always #12.5 clk_in = ~clk_in;
   codec_power_control_reg codec_power_control_reg_i (.clk_in(clk_in), .srst_in(srst_in),
      .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wr_data_in(wdata),
      .reg_rd_data_out(rdata), .reg_rd_valid_out(rd_valid), .sidetone_off_in(off[2]),
      .record_conv_off_in(off[1]), .playback_conv_off_in(off[0]), .record_word_select_pin_in(pin),
      .playback_lr_clock_in(lrclk), .codec_core_pd_out(core), .sidetone_analog_pd_out(side),
      .playback_conv_pd_out(play), .record_conv_pd_out(rec), .virtual_ground_amp_pd_out(vg),
      .hw_pd_out(hw), .out_driver_power_sel_out(drv), .record_ws_pin_func_out(wsf),
      .bias_level_sel_out(bias), .effects_filter_en_out(eff), .deemphasis_en_out(deem),
      .record_ws_out(ws), .sidetone_pd_done_out(side_d), .record_conv_pd_done_out(rec_d),
      .playback_conv_pd_done_out(play_d));
   analog_model #(.DLY(3)) analog_model_i (.clk_in(clk_in), .pd_in({side, rec, play}), .off_out(off));
   task automatic stop_test();
      if (fails == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge clk_in);
      #2 wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(posedge clk_in);
      #2 wr_en = 1'b0;
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
      @(posedge clk_in);
      #2 rd_en = 1'b1;
      addr = a;
      @(posedge clk_in);
      #2 rd_en = 1'b0;
      `CHK(rd_valid, 1'b1)
      `CHK(rdata, exp)
   endtask
   task automatic t_reset();
      rd_chk(7'h05, 16'hAFC0);
      `CHK({core, side, play, rec, vg}, 5'h1F)
      `CHK({drv, wsf, bias, eff, deem}, 5'h00)
   endtask
   task automatic t_power();
      wr(7'h05, 16'h0000);
      `CHK({core, side, play, rec, vg}, 5'h00)
      repeat (SETTLE) @(posedge clk_in);
      rd_chk(7'h05, 16'h0000);
      wr(7'h05, 16'h0700);
      // The converters are not yet off, so their flags must still report in progress.
      `CHK({rec_d, play_d}, 2'h0)
      repeat (SETTLE) @(posedge clk_in);
      `CHK({side_d, rec_d, play_d}, 3'h3)
      rd_chk(7'h05, 16'h07C0);
   endtask
   task automatic t_modes();
      int bits [5] = '{12, 5, 4, 1, 0};
      for (int k = 0; k < 5; k++)
      begin
         wr(7'h05, 16'h0001 << bits[k]);
         `CHK({drv, wsf, bias, eff, deem}, 5'h10 >> k)
         rd_chk(7'h05, 16'h0001 << bits[k]);
      end
   endtask
   task automatic t_refused();
      wr(7'h05, 16'h48CC);
      repeat (SETTLE) @(posedge clk_in);
      rd_chk(7'h05, 16'h0000);
      wr(7'h06, 16'hFFFF);
      `CHK({core, side, play, rec, vg}, 5'h00)
      rd_chk(7'h06, 16'h0000);
      rd_chk(7'h05, 16'h0000);
   endtask
   task automatic t_pin();
      // The record converter is powered down before the power-down pin is driven high.
      wr(7'h05, 16'h0200);
      pin = 1'b1;
      repeat (SETTLE) @(posedge clk_in);
      `CHK({hw, core, side, play, vg}, 5'h1F)
      // The pin pass, the analog delay and the flag pass chain up, so the flags need a second settle.
      repeat (SETTLE) @(posedge clk_in);
      rd_chk(7'h05, 16'h0AC0);
      lrclk = 1'b1;
      repeat (6) @(posedge clk_in);
      `CHK(ws, 1'b1)
      lrclk = 1'b0;
      repeat (6) @(posedge clk_in);
      `CHK(ws, 1'b0)
      wr(7'h05, 16'h0020);
      repeat (6) @(posedge clk_in);
      `CHK({hw, core, ws}, 3'h1)
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_in);
      fails++;
      stop_test();
   end
   initial
   begin
      repeat (8) @(posedge clk_in);
      #2 srst_in = 1'b0;
      t_reset();
      t_power();
      t_modes();
      t_refused();
      t_pin();
      stop_test();
   end
endmodule
